// file: config_word_code_protect.sv
// configuration word store, protection decode and wishbone access
// Function
// - programmed bits read zero, erased read one
// - word lives at address 2007h
// - 2000h-3FFFh reachable only in programming mode
// - protection pairs replicated at 13-8, 5-4
// - 2K decode: 10, 01, 00 ranges
// - 1K decode: 10 whole, 01, 00 ranges
// - 0.5K: any protecting code covers all
// - code 11 leaves memory unprotected
// - watchdog bit one enables, zero disables
`timescale 1ns/1ps
`include "config_word_cfg.svh"

module config_word_code_protect
    import config_word_pkg::*;
#(
    parameter mem_size_e              MEM_SIZE  = MEM_2K,
    parameter logic [`CFG_WORD_W-1:0] INIT_WORD = `CFG_ERASED_WORD
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // programming mode entry pin, asynchronous
    input  wire logic        prog_mode_i,
    // decoded configuration
    output logic [1:0]       protect_pair_code_o,
    output logic             protect_active_o,
    output logic [10:0]      protect_lo_o,
    output logic [10:0]      protect_hi_o,
    output logic             pair_mismatch_o,
    output logic             watchdog_en_o,
    output logic             brownout_reset_en_o,
    output logic             powerup_timer_en_o,
    output logic [1:0]       osc_select_o
);

    logic [`CFG_WORD_W-1:0] word;
    logic [`CFG_WORD_W-1:0] next_word;
    logic                   prog_m1;
    logic                   prog_m2;
    logic                   prog_m3;
    logic                   prog_mode;
    logic                   next_prog_mode;
    logic                   ack;
    logic                   next_ack;
    logic [31:0]            rdata;
    logic [31:0]            next_rdata;
    logic [13:0]            idx;
    logic                   req;
    logic                   in_region;
    logic [1:0]             pair_a;
    logic [1:0]             pair_b;
    logic [1:0]             pair_c;
    logic [1:0]             pair_d;
    logic [1:0]             pair_code;
    logic                   mismatch;
    logic                   dec_protect;
    logic [10:0]            dec_lo;
    logic [10:0]            dec_hi;
    logic [1:0]             out_code;
    logic [1:0]             next_out_code;
    logic                   out_prot;
    logic                   next_out_prot;
    logic [10:0]            out_lo;
    logic [10:0]            next_out_lo;
    logic [10:0]            out_hi;
    logic [10:0]            next_out_hi;
    logic                   out_mism;
    logic                   next_out_mism;
    logic [5:0]             out_misc;
    logic [5:0]             next_out_misc;

    // programming pin crosses in; change counts once m2 and m3 agree
    always_comb begin
        next_prog_mode = prog_mode;
        if (prog_m2 == prog_m3) begin
            next_prog_mode = prog_m3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_m1   <= 1'b0;
            prog_m2   <= 1'b0;
            prog_m3   <= 1'b0;
            prog_mode <= 1'b0;
        end else begin
            prog_m1   <= prog_mode_i;
            prog_m2   <= prog_m1;
            prog_m3   <= prog_m2;
            prog_mode <= next_prog_mode;
        end
    end

    // bus decode; the word index is the byte address over four
    assign idx       = adr_i[15:2];
    assign req       = cyc_i && stb_i && !ack;
    assign in_region = (idx >= `CFG_REGION_LO) &&
                       (idx <= `CFG_REGION_HI);

    // the four copies of the protection pair
    assign pair_a = word[`CFG_PAIR_A_HI -: 2];
    assign pair_b = word[`CFG_PAIR_B_HI -: 2];
    assign pair_c = word[`CFG_PAIR_C_HI -: 2];
    assign pair_d = word[`CFG_PAIR_D_HI -: 2];
    // a copy that disagrees must not weaken protection, so and them
    assign pair_code = pair_a & pair_b & pair_c & pair_d;
    assign mismatch  = (pair_a != pair_b) || (pair_a != pair_c) ||
                       (pair_a != pair_d);

    // write path: programming can only clear bits, never set them
    always_comb begin
        next_word = word;
        if (req && we_i && in_region && prog_mode &&
            (idx == `CFG_WORD_IDX)) begin
            if (sel_i[0]) begin
                next_word[7:0] = word[7:0] & dat_i[7:0];
            end
            if (sel_i[1]) begin
                next_word[13:8] = word[13:8] & dat_i[13:8];
            end
        end
    end

    // read path and single-cycle ack; unmapped reads give zero
    always_comb begin
        next_ack   = req;
        next_rdata = 32'h0000_0000;
        if (req && !we_i) begin
            if (idx == `CFG_STATUS_IDX) begin
                next_rdata[`CFG_ST_PROG_BIT] = prog_mode;
                next_rdata[`CFG_ST_MISM_BIT] = mismatch;
                next_rdata[`CFG_ST_PROT_BIT] = dec_protect;
            end else if (in_region && prog_mode &&
                         (idx == `CFG_WORD_IDX)) begin
                next_rdata[`CFG_WORD_W-1:0] = word;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    // the stored word models nonvolatile cells; reset reloads INIT_WORD, dropping programmed bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word <= INIT_WORD;
        end else begin
            word <= next_word;
        end
    end

    protect_range_decode u_decode (
        .code_i     (pair_code),
        .mem_size_i (MEM_SIZE),
        .protect_o  (dec_protect),
        .lo_o       (dec_lo),
        .hi_o       (dec_hi)
    );

    // outputs follow the word only outside programming, so a half
    // programmed word never reaches the rest of the chip
    always_comb begin
        next_out_code = out_code;
        next_out_prot = out_prot;
        next_out_lo   = out_lo;
        next_out_hi   = out_hi;
        next_out_mism = out_mism;
        next_out_misc = out_misc;
        if (!prog_mode) begin
            next_out_code = pair_code;
            next_out_prot = dec_protect;
            next_out_lo   = dec_lo;
            next_out_hi   = dec_hi;
            next_out_mism = mismatch;
            next_out_misc = {word[`CFG_BOR_BIT],
                             word[`CFG_PWRT_BIT],
                             word[`CFG_WDT_BIT],
                             1'b0,
                             word[`CFG_OSC_HI -: 2]};
        end
    end

    // reset shows the erased, unprotected default until loaded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_code <= `CFG_CODE_OFF;
            out_prot <= 1'b0;
            out_lo   <= `CFG_ADDR_ZERO;
            out_hi   <= `CFG_ADDR_ZERO;
            out_mism <= 1'b0;
            out_misc <= 6'h3b;
        end else begin
            out_code <= next_out_code;
            out_prot <= next_out_prot;
            out_lo   <= next_out_lo;
            out_hi   <= next_out_hi;
            out_mism <= next_out_mism;
            out_misc <= next_out_misc;
        end
    end

    assign ack_o               = ack;
    assign dat_o               = rdata;
    assign protect_pair_code_o = out_code;
    assign protect_active_o    = out_prot;
    assign protect_lo_o        = out_lo;
    assign protect_hi_o        = out_hi;
    assign pair_mismatch_o     = out_mism;
    assign brownout_reset_en_o = out_misc[5];
    assign powerup_timer_en_o  = out_misc[4];
    assign watchdog_en_o       = out_misc[3];
    assign osc_select_o        = out_misc[1:0];

endmodule

// file: config_word_cfg.svh
// constants for the configuration word block: offsets, fields, resets
`ifndef CONFIG_WORD_CFG_SVH
`define CONFIG_WORD_CFG_SVH

// register indices; byte address is four times the index
`define CFG_WORD_IDX      14'h2007
`define CFG_STATUS_IDX    14'h0000
`define CFG_REGION_LO     14'h2000
`define CFG_REGION_HI     14'h3fff

// word layout
`define CFG_WORD_W        14
`define CFG_PAIR_A_HI     13
`define CFG_PAIR_B_HI     11
`define CFG_PAIR_C_HI     9
`define CFG_PAIR_D_HI     5
`define CFG_BOR_BIT       6
`define CFG_PWRT_BIT      3
`define CFG_WDT_BIT       2
`define CFG_OSC_HI        1

// status layout
`define CFG_ST_PROG_BIT   0
`define CFG_ST_MISM_BIT   1
`define CFG_ST_PROT_BIT   2

// erased word and reset values
`define CFG_ERASED_WORD   14'h3fff
`define CFG_CODE_OFF      2'h3
`define CFG_ADDR_ZERO     11'h000

// protection range limits
`define CFG_ADDR_200      11'h200
`define CFG_ADDR_400      11'h400
`define CFG_END_2K        11'h7ff
`define CFG_END_1K        11'h3ff
`define CFG_END_HALF      11'h1ff

`endif

// file: config_word_pkg.sv
// types shared by the configuration word block
package config_word_pkg;

    // program memory sizes the protection decode understands
    typedef enum logic [1:0] {
        MEM_2K,
        MEM_1K,
        MEM_HALF
    } mem_size_e;

endpackage

// file: protect_range_decode.sv
// decodes one protection pair into a protected address window
`timescale 1ns/1ps
`include "config_word_cfg.svh"

module protect_range_decode
    import config_word_pkg::*;
(
    input  wire logic [1:0]  code_i,
    input  wire mem_size_e   mem_size_i,
    output logic             protect_o,
    output logic [10:0]      lo_o,
    output logic [10:0]      hi_o
);

    // window per memory size; pure table, no state
    always_comb begin
        protect_o = (code_i != `CFG_CODE_OFF);
        lo_o      = `CFG_ADDR_ZERO;
        hi_o      = `CFG_ADDR_ZERO;
        unique case (mem_size_i)
            MEM_2K: begin
                hi_o = `CFG_END_2K;
                unique case (code_i)
                    2'h2: lo_o = `CFG_ADDR_400;
                    2'h1: lo_o = `CFG_ADDR_200;
                    2'h0: lo_o = `CFG_ADDR_ZERO;
                    2'h3: hi_o = `CFG_ADDR_ZERO;
                endcase
            end
            MEM_1K: begin
                hi_o = `CFG_END_1K;
                unique case (code_i)
                    2'h2: lo_o = `CFG_ADDR_ZERO;
                    2'h1: lo_o = `CFG_ADDR_200;
                    2'h0: lo_o = `CFG_ADDR_ZERO;
                    2'h3: hi_o = `CFG_ADDR_ZERO;
                endcase
            end
            MEM_HALF: begin
                // any code but off covers the whole half-size memory
                lo_o = `CFG_ADDR_ZERO;
                hi_o = protect_o ? `CFG_END_HALF
                                 : `CFG_ADDR_ZERO;
            end
            default: begin
                // illegal size code: report nothing protected
                protect_o = 1'b0;
            end
        endcase
    end

endmodule

// file: config_word_asserts.sv
// port checker for the configuration word block
`timescale 1ns/1ps
module config_word_asserts
    import config_word_pkg::*;
#(
    parameter mem_size_e MEM_SIZE = MEM_2K
)
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [15:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        prog_mode_i,
    input wire logic [1:0]  protect_pair_code_o,
    input wire logic        protect_active_o,
    input wire logic [10:0] protect_lo_o,
    input wire logic [10:0] protect_hi_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // pin low long enough for the synchroniser to drain
    sequence s_pin_low; !prog_mode_i [*8]; endsequence
    sequence s_word_rd;
        cyc_i && stb_i && !we_i && !ack_o && adr_i == 16'h801c;
    endsequence
    wire req = cyc_i && stb_i && !ack_o;
    wire off = protect_pair_code_o == 2'h3;
    wire k2 = MEM_SIZE == MEM_2K;
    a_ack_next: assert property (req |=> ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_upper_zero: assert property (ack_o |-> dat_o[31:14] == 18'h0)
        else $error("upper read bits set");
    a_locked_read: assert property (s_pin_low ##0 s_word_rd |=>
        dat_o == 32'h0) else $error("word read outside programming");
    a_off_clear: assert property (off |-> !protect_active_o &&
        protect_lo_o == 11'h0 && protect_hi_o == 11'h0)
        else $error("window set with protection off");
    a_active_flag: assert property (protect_active_o == !off)
        else $error("active flag wrong");
    a_2k_end: assert property (k2 && !off |-> protect_hi_o == 11'h7ff)
        else $error("window end wrong");
    a_2k_start: assert property (k2 && !off |-> protect_lo_o ==
        (protect_pair_code_o == 2'h2 ? 11'h400 :
         protect_pair_code_o == 2'h1 ? 11'h200 : 11'h000))
        else $error("window start wrong");
endmodule
bind config_word_code_protect config_word_asserts #(.MEM_SIZE(MEM_SIZE))
    u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .prog_mode_i(prog_mode_i), .protect_pair_code_o(protect_pair_code_o),
    .protect_active_o(protect_active_o), .protect_lo_o(protect_lo_o),
    .protect_hi_o(protect_hi_o));

// file: prog_pin_model.sv
// programmer side model: drives the programming mode pin
`timescale 1ns/1ps
module prog_pin_model (
    input  wire logic clk_i,
    input  wire logic enter_i,
    output logic      prog_mode_o
);
    // pin raised before the region is touched, dropped after
    always_ff @(posedge clk_i) begin
        prog_mode_o <= enter_i;
    end
endmodule

// file: config_word_code_protect_bench.sv
// self-checking bench for the configuration word block
`timescale 1ns/1ps
module config_word_code_protect_bench;
    import config_word_pkg::*;
    typedef struct packed {
        logic [13:0] word;
        logic [30:0] outs;
    } row_s;
    // words only ever clear bits, so rows descend
    localparam row_s ROWS [4] = '{
        '{14'h3fff, {2'h3, 1'h0, 11'h000, 11'h000, 4'h7, 2'h3}},
        '{14'h1fff, {2'h1, 1'h1, 11'h200, 11'h7ff, 4'hf, 2'h3}},
        '{14'h15df, {2'h1, 1'h1, 11'h200, 11'h7ff, 4'h7, 2'h3}},
        '{14'h0089, {2'h0, 1'h1, 11'h000, 11'h7ff, 4'h1, 2'h1}}};
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, enter, prog;
    logic [15:0] adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic        ack_o, code_on, mism, wdt, bor, pwrt;
    logic [1:0]  code, osc;
    logic [10:0] lo, hi;
    int          err_total, n_compared;
    wire  [30:0] outs = {code, code_on, lo, hi, mism, wdt, bor, pwrt, osc};
    config_word_code_protect u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .prog_mode_i(prog), .protect_pair_code_o(code),
        .protect_active_o(code_on), .protect_lo_o(lo), .protect_hi_o(hi),
        .pair_mismatch_o(mism), .watchdog_en_o(wdt),
        .brownout_reset_en_o(bor), .powerup_timer_en_o(pwrt),
        .osc_select_o(osc));
    prog_pin_model u_prog (.clk_i(clk_i), .enter_i(enter),
        .prog_mode_o(prog));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_cfg(input logic [30:0] e);
        n_compared++;
        if (outs !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, outs, e);
        end
    endtask
    // one classic cycle; ack and data are taken at the same rising edge
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            err_total++;
            print_verdict();
        end
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    // pin change then six edges for synchroniser and reload
    task automatic pin(input logic v);
        @(posedge clk_i);
        enter <= v;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    initial begin
        err_total = 0; n_compared = 0; rst_i = 1'b1; enter = 1'b0;
        cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 16'h0;
        sel_i = 4'h3; dat_i = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        pin(1'b0);
        chk_cfg(ROWS[0].outs);
        wb(1'b1, 16'h801c, 32'h0, q);
        wb(1'b0, 16'h801c, 32'h0, q);
        chk_bus(q, 32'h0);
        wb(1'b0, 16'h8020, 32'h0, q);
        chk_bus(q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pin(1'b1);
            wb(1'b1, 16'h801c, {18'h0, ROWS[i].word}, q);
            wb(1'b0, 16'h801c, 32'h0, q);
            chk_bus(q, {18'h0, ROWS[i].word});
            chk_cfg(ROWS[i == 0 ? 0 : i - 1].outs);
            pin(1'b0);
            chk_cfg(ROWS[i].outs);
        end
        pin(1'b1);
        wb(0, 16'h0000, 32'h0, q);
        chk_bus(q & 32'h1, 32'h1);
        wb(1'b1, 16'h801c, 32'h3fff, q);
        wb(1'b0, 16'h801c, 32'h0, q);
        chk_bus(q, 32'h0089);
        wb(1'b0, 16'h0100, 32'h0, q);
        chk_bus(q, 32'h0);
        print_verdict();
    end
endmodule
